//--- dcsl_defines.vh
/*
 * register offsets, field positions, reset values and timing counts for
 * the detect/charge status latch bank.
 * assumes a 100 MHz system clock and a 32-bit axi4-lite register port.
 */
`ifndef DCSL_DEFINES_VH
`define DCSL_DEFINES_VH

// ==========================================================================
// register byte offsets
// ==========================================================================
`define DCSL_OFS_ID_EVENT      8'h01
`define DCSL_OFS_DET_EVENT     8'h02
`define DCSL_OFS_CHG_EVENT     8'h03
`define DCSL_OFS_ID_STATUS     8'h04
`define DCSL_OFS_DET_STATUS    8'h05
`define DCSL_OFS_CHG_STATUS    8'h06
`define DCSL_OFS_ID_MASK       8'h07
`define DCSL_OFS_DET_MASK      8'h08
`define DCSL_OFS_CHG_MASK      8'h09
`define DCSL_OFS_DET_CTRL      8'h0B

// ==========================================================================
// field positions
// ==========================================================================
`define DCSL_CHG_BATT_CHG      5
`define DCSL_CHG_ENBL_CHG      4
`define DCSL_CHG_TMR_CHG       3
`define DCSL_CHG_OVP_CHG       2
`define DCSL_CHG_PGOOD_CHG     1
`define DCSL_CHG_DONE_CHG      0
`define DCSL_ID_KOHM           7
`define DCSL_ID_FAULT          6
`define DCSL_ID_LOWRES         5
`define DCSL_DET_VIDEO_LOAD_REMOVED         7
`define DCSL_DET_VBUS          6
`define DCSL_DET_DATA_LINE_OVERVOLTAGE         5
`define DCSL_DET_CONTACT_TIMER_EXPIRED        4
`define DCSL_DET_RUN           3
`define DCSL_CTRL_VIDEO_LOAD_REMOVED_EN     1

// ==========================================================================
// reset values and encodings
// ==========================================================================
`define DCSL_MASK_RST          8'h00
`define DCSL_CTYPE_NONE        3'h0
`define DCSL_DEC_ERR           2'h3
`define DCSL_RESP_OK           2'h0

// ==========================================================================
// timing: contact detection timer, 2 s least time
// ==========================================================================
`define DCSL_DCD_TIME_MS       2000
`define DCSL_CLK_KHZ           100000
`define DCSL_DCD_CYCLES        (`DCSL_DCD_TIME_MS * `DCSL_CLK_KHZ)

`endif

//--- dcsl_status_latches.v
/*
 * detect/charge status latch bank: status, clear-on-read latches, masks,
 * active-low interrupt, axi4-lite port.
 * assumes async detector levels, one clock, sync active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dcsl_defines.vh"

module dcsl_status_latches #(
  parameter [31:0] DCD_CYCLES = `DCSL_DCD_CYCLES  // contact timer length in cycles
) (
  input  wire        clk_i,
  input  wire        reset_i,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output wire [1:0]  s_axi_bresp_o,
  output wire        s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0]  s_axi_rresp_o,
  output wire        s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  // charger detectors
  input  wire [1:0]  battery_presence_field_i,
  input  wire        charger_enabled_flag_i,
  input  wire        fast_charge_timer_expired_i,
  input  wire        bus_overvoltage_flag_i,
  input  wire        charger_power_good_i,
  input  wire        charge_done_i,
  // identification detectors
  input  wire        id_kilohm_detect_i,
  input  wire        id_convert_fault_i,
  input  wire        id_low_resistance_flag_i,
  input  wire [4:0]  id_result_i,
  // charger-type detectors
  input  wire        video_load_removed_i,
  input  wire        video_amp_active_i,
  input  wire        bus_voltage_detect_i,
  input  wire        data_line_overvoltage_i,
  input  wire        contact_timer_run_i,
  input  wire        detect_request_i,
  input  wire [2:0]  detected_type_i,
  // outputs
  output wire        detect_enable_o,
  output wire        irq_n_o
);

  // ========================================================================
  // input synchronisers
  // ========================================================================
  localparam SYNC_W = 24;
  wire [SYNC_W-1:0] raw_in;            // asynchronous detector levels
  reg  [SYNC_W-1:0] sync1_ff;          // first stage, read only by stage two
  reg  [SYNC_W-1:0] sync2_ff;          // stable copies

  assign raw_in = {battery_presence_field_i, charger_enabled_flag_i,
                   fast_charge_timer_expired_i, bus_overvoltage_flag_i,
                   charger_power_good_i, charge_done_i, id_kilohm_detect_i,
                   id_convert_fault_i, id_low_resistance_flag_i, id_result_i,
                   video_load_removed_i, video_amp_active_i,
                   bus_voltage_detect_i, data_line_overvoltage_i,
                   contact_timer_run_i, detect_request_i, detected_type_i};

  // two flops before any logic
  always @(posedge clk_i) begin
    if (reset_i) begin
      sync1_ff <= {SYNC_W{1'b0}};
      sync2_ff <= {SYNC_W{1'b0}};
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  wire [1:0] s_batt   = sync2_ff[23:22];
  wire       s_enbl   = sync2_ff[21];
  wire       s_tmr    = sync2_ff[20];
  wire       s_ovp    = sync2_ff[19];
  wire       s_pgood  = sync2_ff[18];
  wire       s_done   = sync2_ff[17];
  wire       s_kohm   = sync2_ff[16];
  wire       s_fault  = sync2_ff[15];
  wire       s_lowres = sync2_ff[14];
  wire [4:0] s_result = sync2_ff[13:9];
  wire       s_video_load_removed  = sync2_ff[8];
  wire       s_vidamp = sync2_ff[7];
  wire       s_vbus   = sync2_ff[6];
  wire       s_data_line_overvoltage  = sync2_ff[5];
  wire       s_dcdrun = sync2_ff[4];
  wire       s_req    = sync2_ff[3];
  wire [2:0] s_type   = sync2_ff[2:0];

  // ========================================================================
  // software registers
  // ========================================================================
  reg [7:0] id_mask_ff;                // identification event mask
  reg [7:0] det_mask_ff;               // detection event mask
  reg [7:0] chg_mask_ff;               // charger event mask
  reg [7:0] det_ctrl_ff;               // video removal detect enable

  // ========================================================================
  // contact detection timer and detection machine
  // ========================================================================
  localparam ST_IDLE = 1'b0;           // machine idle
  localparam ST_RUN  = 1'b1;           // machine running
  reg        det_state_ff;             // detection machine state
  reg        nxt_det_state;
  reg [31:0] dcd_cnt_ff;               // counts while contact timer runs
  reg        dcd_exp_ff;               // timer has passed its least time
  reg [2:0]  ctype_ff;                 // latched charger type

  // data-line overvoltage only valid with bus voltage present
  wire data_line_overvoltage_q = s_data_line_overvoltage & s_vbus;

  // machine next state: overvoltage forces it off
  always @* begin
    nxt_det_state = det_state_ff;
    case (det_state_ff)
      ST_IDLE: begin
        if (s_req && !data_line_overvoltage_q && s_vbus) begin
          nxt_det_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (data_line_overvoltage_q || !s_req || !s_vbus) begin
          nxt_det_state = ST_IDLE;
        end
      end
      default: nxt_det_state = ST_IDLE;
    endcase
  end

  // state, timer and type capture
  always @(posedge clk_i) begin
    if (reset_i) begin
      det_state_ff <= ST_IDLE;
      dcd_cnt_ff   <= 32'h00000000;
      dcd_exp_ff   <= 1'b0;
      ctype_ff     <= `DCSL_CTYPE_NONE;
    end else begin
      det_state_ff <= nxt_det_state;
      if (!s_dcdrun) begin
        dcd_cnt_ff <= 32'h00000000;
        dcd_exp_ff <= 1'b0;
      end else if (dcd_cnt_ff >= DCD_CYCLES - 32'h00000001) begin
        dcd_exp_ff <= 1'b1;
      end else begin
        dcd_cnt_ff <= dcd_cnt_ff + 32'h00000001;
      end
      if (data_line_overvoltage_q) begin
        ctype_ff <= `DCSL_CTYPE_NONE;
      end else begin
        ctype_ff <= s_type;
      end
    end
  end

  // ========================================================================
  // live status words
  // ========================================================================
  wire video_load_removed_q = s_video_load_removed & det_ctrl_ff[`DCSL_CTRL_VIDEO_LOAD_REMOVED_EN] & s_vidamp;
  wire [7:0] id_status  = {s_kohm, s_fault, s_lowres, s_result};
  wire [7:0] det_status = {video_load_removed_q, s_vbus, data_line_overvoltage_q, dcd_exp_ff,
                           det_state_ff, ctype_ff};
  wire [7:0] chg_status = {1'b0, s_batt, s_enbl, s_tmr, s_ovp, s_pgood, s_done};

  reg  [7:0] id_prev_ff;               // last seen status values
  reg  [7:0] det_prev_ff;
  reg  [7:0] chg_prev_ff;
  reg  [7:0] id_evt_ff;                // change latches
  reg  [7:0] det_evt_ff;
  reg  [7:0] chg_evt_ff;

  // map a status change vector onto latch bit positions
  function [7:0] id_chg;
    input [7:0] d;
    begin
      id_chg = {4'h0, d[7], d[6], d[5], |d[4:0]};
    end
  endfunction

  function [7:0] det_chg;
    input [7:0] d;
    begin
      det_chg = {2'h0, d[7], d[6], d[5], d[4], d[3], |d[2:0]};
    end
  endfunction

  function [7:0] chg_chg;
    input [7:0] d;
    begin
      chg_chg = {2'h0, |d[6:5], d[4], d[3], d[2], d[1], d[0]};
    end
  endfunction

  wire [7:0] id_set  = id_chg(id_status ^ id_prev_ff);
  wire [7:0] det_set = det_chg(det_status ^ det_prev_ff);
  wire [7:0] chg_set = chg_chg(chg_status ^ chg_prev_ff);

  // ========================================================================
  // axi4-lite slave
  // ========================================================================
  reg        aw_ff;                    // write address held
  reg [7:0]  awaddr_ff;
  reg        w_ff;                     // write data held
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  reg        bvalid_ff;
  reg [1:0]  bresp_ff;
  reg        rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0]  rresp_ff;

  assign s_axi_awready_o = !aw_ff && !bvalid_ff;
  assign s_axi_wready_o  = !w_ff && !bvalid_ff;
  assign s_axi_arready_o = !rvalid_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rdata_o   = rdata_ff;
  assign s_axi_rresp_o   = rresp_ff;

  wire       rd_go = s_axi_arvalid_i && !rvalid_ff;
  wire       wr_go = aw_ff && w_ff && !bvalid_ff;
  wire [7:0] ra    = s_axi_araddr_i;
  wire       wr_ok = wrstb_map(awaddr_ff);

  // writable word decode
  function wrstb_map;
    input [7:0] a;
    begin
      wrstb_map = (a == `DCSL_OFS_ID_MASK) || (a == `DCSL_OFS_DET_MASK) ||
                  (a == `DCSL_OFS_CHG_MASK) || (a == `DCSL_OFS_DET_CTRL);
    end
  endfunction

  // clearing read strobes
  wire clr_id  = rd_go && (ra == `DCSL_OFS_ID_EVENT);
  wire clr_det = rd_go && (ra == `DCSL_OFS_DET_EVENT);
  wire clr_chg = rd_go && (ra == `DCSL_OFS_CHG_EVENT);

  // read mux
  reg [7:0] rd_byte;
  reg       rd_hit;
  always @* begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (ra)
      `DCSL_OFS_ID_EVENT:   rd_byte = id_evt_ff;
      `DCSL_OFS_DET_EVENT:  rd_byte = det_evt_ff;
      `DCSL_OFS_CHG_EVENT:  rd_byte = chg_evt_ff;
      `DCSL_OFS_ID_STATUS:  rd_byte = id_status;
      `DCSL_OFS_DET_STATUS: rd_byte = det_status;
      `DCSL_OFS_CHG_STATUS: rd_byte = chg_status;
      `DCSL_OFS_ID_MASK:    rd_byte = id_mask_ff;
      `DCSL_OFS_DET_MASK:   rd_byte = det_mask_ff;
      `DCSL_OFS_CHG_MASK:   rd_byte = chg_mask_ff;
      `DCSL_OFS_DET_CTRL:   rd_byte = det_ctrl_ff;
      default:              rd_hit  = 1'b0;
    endcase
  end

  // bus handshakes, mask writes, latches
  always @(posedge clk_i) begin
    if (reset_i) begin
      aw_ff       <= 1'b0;
      awaddr_ff   <= 8'h00;
      w_ff        <= 1'b0;
      wdata_ff    <= 32'h00000000;
      wstrb_ff    <= 4'h0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= `DCSL_RESP_OK;
      rvalid_ff   <= 1'b0;
      rdata_ff    <= 32'h00000000;
      rresp_ff    <= `DCSL_RESP_OK;
      id_mask_ff  <= `DCSL_MASK_RST;
      det_mask_ff <= `DCSL_MASK_RST;
      chg_mask_ff <= `DCSL_MASK_RST;
      det_ctrl_ff <= 8'h00;
      id_prev_ff  <= 8'h00;
      det_prev_ff <= 8'h00;
      chg_prev_ff <= 8'h00;
      id_evt_ff   <= 8'h00;
      det_evt_ff  <= 8'h00;
      chg_evt_ff  <= 8'h00;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? `DCSL_RESP_OK : `DCSL_DEC_ERR;
        if (wstrb_ff[0]) begin
          case (awaddr_ff)
            `DCSL_OFS_ID_MASK:  id_mask_ff  <= {4'h0, wdata_ff[3:0]};
            `DCSL_OFS_DET_MASK: det_mask_ff <= {2'h0, wdata_ff[5:0]};
            `DCSL_OFS_CHG_MASK: chg_mask_ff <= {2'h0, wdata_ff[5:0]};
            `DCSL_OFS_DET_CTRL: det_ctrl_ff <= {6'h00, wdata_ff[1:0]};
            default:            bresp_ff    <= `DCSL_DEC_ERR;
          endcase
        end
      end else if (bvalid_ff && s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h000000, rd_byte};
        rresp_ff  <= rd_hit ? `DCSL_RESP_OK : `DCSL_DEC_ERR;
      end else if (rvalid_ff && s_axi_rready_i) begin
        rvalid_ff <= 1'b0;
      end
      id_prev_ff  <= id_status;
      det_prev_ff <= det_status;
      chg_prev_ff <= chg_status;
      // new changes win over a clearing read
      id_evt_ff  <= (clr_id  ? 8'h00 : id_evt_ff)  | id_set;
      det_evt_ff <= (clr_det ? 8'h00 : det_evt_ff) | det_set;
      chg_evt_ff <= (clr_chg ? 8'h00 : chg_evt_ff) | chg_set;
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================
  reg irq_n_ff;                        // registered active-low interrupt
  always @(posedge clk_i) begin
    if (reset_i) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= ~(|(chg_evt_ff & chg_mask_ff) | |(id_evt_ff & id_mask_ff) |
                    |(det_evt_ff & det_mask_ff));
    end
  end

  assign irq_n_o         = irq_n_ff;
  assign detect_enable_o = det_state_ff;

endmodule // dcsl_status_latches
`default_nettype wire

//--- dcsl_checker.sv
/* dcsl_checker: timing checks on the bus answers, the detect enable and
   the interrupt of the status latch bank.
   assumes it is bound into dcsl_status_latches: one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
`include "dcsl_defines.vh"
module dcsl_checker #(
  parameter [31:0] DCD_CYCLES = `DCSL_DCD_CYCLES  // contact timer length
) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        bus_voltage_detect_i,
  input wire logic        data_line_overvoltage_i,
  input wire logic        detect_request_i,
  input wire logic        detect_enable_o,
  input wire logic        irq_n_o
);
  // ==========================================================================
  // helper state
  // ==========================================================================
  logic wr_seen_ff;   // set once any write address was taken
  // until a write lands every mask is still 0
  always_ff @(posedge clk_i) begin
    wr_seen_ff <= !reset_i && (wr_seen_ff || (s_axi_awvalid_i && s_axi_awready_o));
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================================
  // sequences
  // ==========================================================================
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  // ==========================================================================
  // assertions
  // ==========================================================================
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response missing");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid_o)
    else $error("read data missing");
  a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken while data pending");
  a_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_read: assert property (s_rd_taken ##0 s_axi_araddr_i >= 8'h0C |=>
    s_axi_rresp_o == `DCSL_DEC_ERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read answered wrongly");
  a_chg_rsvd: assert property (
    s_rd_taken ##0 s_axi_araddr_i == `DCSL_OFS_CHG_EVENT |=> s_axi_rdata_o[7:6] == 2'h0)
    else $error("reserved event bits set");
  a_irq_no_mask: assert property (!wr_seen_ff |-> irq_n_o)
    else $error("interrupt while all masks are zero");
  a_ovp_forces_off: assert property (
    (data_line_overvoltage_i && bus_voltage_detect_i)[*4] |=> !detect_enable_o)
    else $error("detection runs under overvoltage");
  a_run_follows: assert property (
    (detect_request_i && bus_voltage_detect_i && !data_line_overvoltage_i)[*4]
    |=> detect_enable_o)
    else $error("detection not running");
  a_run_needs_bus: assert property (
    (!bus_voltage_detect_i)[*4] |=> !detect_enable_o)
    else $error("detection runs without bus voltage");
endmodule  // dcsl_checker
bind dcsl_status_latches dcsl_checker #(.DCD_CYCLES(DCD_CYCLES)) u_checker (
  .clk_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .bus_voltage_detect_i, .data_line_overvoltage_i, .detect_request_i,
  .detect_enable_o, .irq_n_o);
`default_nettype wire

//--- dcsl_host_model.sv
/* dcsl_host_model: axi4-lite host that services the latch bank.
   assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module dcsl_host_model (
  input  wire logic        clk_i,
  output var  logic [7:0]  awaddr_o,
  output var  logic        awvalid_o,
  input  wire logic        awready_i,
  output var  logic [31:0] wdata_o,
  output var  logic [3:0]  wstrb_o,
  output var  logic        wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output var  logic        bready_o,
  output var  logic [7:0]  araddr_o,
  output var  logic        arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output var  logic        rready_o,
  output var  logic        hang_o
);
  localparam int LIMIT = 64;  // cycles allowed for one answer
  // bus idle at time zero
  initial {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o,
           araddr_o, arvalid_o, rready_o, hang_o} = '0;
  // ==========================================================================
  // one write: aw and w together
  // ==========================================================================
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    awaddr_o  <= a;
    wdata_o   <= v;
    wstrb_o   <= 4'hF;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    for (n = 0; n < LIMIT; n++) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
      if (bvalid_i) break;
    end
    r = bresp_i;
    bready_o <= 1'b0;
    if (n == LIMIT) hang_o <= 1'b1;
  endtask
  // ==========================================================================
  // one read
  // ==========================================================================
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    for (n = 0; n < LIMIT; n++) begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'b0;
      if (rvalid_i) break;
    end
    v = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
    if (n == LIMIT) hang_o <= 1'b1;
  endtask
endmodule  // dcsl_host_model
`default_nettype wire

//--- tb_detect_charge_status_latches.sv
/* tb_detect_charge_status_latches: self-checking bench for the latch bank.
   assumes the host model drives the bus and a 20-cycle contact timer. */
`timescale 1ns/1ps
`default_nettype none
`include "dcsl_defines.vh"
module tb_detect_charge_status_latches;
  localparam [31:0] DCD = 32'd20;            // shortened contact timer
  logic        clk_i, reset_i, hang;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic        s_axi_rvalid_o, s_axi_rready_i, detect_enable_o, irq_n_o;
  logic [6:0]  chg;     // charger levels
  logic [7:0]  idv;     // id levels
  logic        vbus, data_line_overvoltage, video_load_removed, vamp, dcdrun, dreq;
  logic [2:0]  dtype;   // detector type
  logic [31:0] d, d2, e;
  logic [1:0]  r;
  int          n_mismatch = 0, num_checks = 0, i;
  dcsl_status_latches #(.DCD_CYCLES(DCD)) u_dut (
    .clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .battery_presence_field_i(chg[6:5]), .charger_enabled_flag_i(chg[4]),
    .fast_charge_timer_expired_i(chg[3]), .bus_overvoltage_flag_i(chg[2]),
    .charger_power_good_i(chg[1]), .charge_done_i(chg[0]), .id_kilohm_detect_i(idv[7]),
    .id_convert_fault_i(idv[6]), .id_low_resistance_flag_i(idv[5]), .id_result_i(idv[4:0]),
    .video_load_removed_i(video_load_removed), .video_amp_active_i(vamp), .bus_voltage_detect_i(vbus),
    .data_line_overvoltage_i(data_line_overvoltage), .contact_timer_run_i(dcdrun), .detect_request_i(dreq),
    .detected_type_i(dtype), .detect_enable_o, .irq_n_o);
  dcsl_host_model u_host (
    .clk_i, .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
    .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
    .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
    .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
    .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i),
    .hang_o(hang));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================================
  // shared helpers
  // ==========================================================================
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("FAIL t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  // read one register and compare the bits under m
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    u_host.rd(a, d, r);
    chk(x, d & m);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset;
    chk(1, irq_n_o);
    for (i = 7; i < 10; i++) rdm(i[7:0], '1, 0);
    u_host.rd(8'h0C, d, r);
    chk(`DCSL_DEC_ERR, r);
    chk(0, d);
  endtask
  // each charger bit, then clearing read
  task automatic t_chg;
    for (i = 0; i < 7; i++) begin
      chg <= chg ^ (7'h01 << i);
      e = 32'h1 << ((i > 4) ? 5 : i);
      repeat (6) @(posedge clk_i);
      rdm(`DCSL_OFS_CHG_EVENT, '1, e);
      rdm(`DCSL_OFS_CHG_EVENT, '1, 0);
    end
    rdm(`DCSL_OFS_CHG_STATUS, '1, 32'h7F);
  endtask
  // done event passed, then masked
  task automatic t_irq;
    u_host.wr(`DCSL_OFS_CHG_MASK, 32'h3F, r);
    chk(`DCSL_RESP_OK, r);
    chg <= chg ^ 7'h01;
    repeat (6) @(posedge clk_i);
    chk(0, irq_n_o);
    rdm(`DCSL_OFS_CHG_EVENT, '1, 1);
    repeat (3) @(posedge clk_i);
    chk(1, irq_n_o);
    u_host.wr(`DCSL_OFS_CHG_MASK, 32'h3E, r);
    chg <= chg ^ 7'h01;
    repeat (6) @(posedge clk_i);
    chk(1, irq_n_o);
    rdm(`DCSL_OFS_CHG_EVENT, '1, 1);
  endtask
  // overvoltage change lands on the edge of the clearing read
  task automatic t_race;
    chg <= chg ^ 7'h04;
    @(posedge clk_i);
    u_host.rd(`DCSL_OFS_CHG_EVENT, d2, r);
    rdm(`DCSL_OFS_CHG_EVENT, 32'h4, 32'h4 & ~d2);
  endtask
  task automatic t_id;
    logic [7:0] v [5];
    logic [7:0] x;
    v = '{8'h80, 8'hC0, 8'h20, 8'h33, 8'h00};
    for (i = 0; i < 5; i++) begin
      x = idv ^ v[i];
      idv <= v[i];
      repeat (6) @(posedge clk_i);
      rdm(`DCSL_OFS_ID_STATUS, 32'hE0, {24'h0, v[i][7:5], 5'h0});
      if (i == 2) chk(1, d[5] && d[4:0] == 5'h0);
      rdm(`DCSL_OFS_ID_EVENT, 32'hF, {28'h0, x[7:5], |x[4:0]});
    end
  endtask
  // each charger type, overvoltage, no bus
  task automatic t_det;
    vbus <= 1'b1;
    dreq <= 1'b1;
    for (i = 0; i < 8; i++) begin
      dtype <= i[2:0];
      repeat (6) @(posedge clk_i);
      rdm(`DCSL_OFS_DET_STATUS, '1, 32'h48 | i);
      chk(1, detect_enable_o);
    end
    data_line_overvoltage <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdm(`DCSL_OFS_DET_STATUS, '1, 32'h60);
    vbus <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdm(`DCSL_OFS_DET_STATUS, 32'hF8, 0);
  endtask
  // removal flag needs enable and amplifier
  task automatic t_video;
    vbus <= 1'b1;
    data_line_overvoltage <= 1'b0;
    video_load_removed <= 1'b1;
    vamp <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdm(`DCSL_OFS_DET_STATUS, 32'h80, 0);
    u_host.wr(`DCSL_OFS_DET_CTRL, 32'h1 << `DCSL_CTRL_VIDEO_LOAD_REMOVED_EN, r);
    repeat (4) @(posedge clk_i);
    rdm(`DCSL_OFS_DET_STATUS, 32'h80, 32'h80);
    vamp <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdm(`DCSL_OFS_DET_STATUS, 32'h80, 0);
  endtask
  task automatic t_dcd;
    dcdrun <= 1'b1;
    repeat (8) @(posedge clk_i);
    rdm(`DCSL_OFS_DET_STATUS, 32'h10, 0);
    u_host.rd(`DCSL_OFS_DET_EVENT, d, r);
    repeat (DCD) @(posedge clk_i);
    rdm(`DCSL_OFS_DET_STATUS, 32'h10, 32'h10);
    rdm(`DCSL_OFS_DET_EVENT, 32'h4, 32'h4);
    dcdrun <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdm(`DCSL_OFS_DET_STATUS, 32'h10, 0);
  endtask
  // ==========================================================================
  // main sequence and hang guard
  // ==========================================================================
  initial begin
    reset_i = 1'b1;
    {chg, idv, vbus, data_line_overvoltage, video_load_removed, vamp, dcdrun, dreq, dtype} = '0;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset;
    t_chg;
    t_irq;
    t_race;
    t_id;
    t_det;
    t_video;
    t_dcd;
    summarize;
  end
  always @(posedge clk_i) begin
    if (hang === 1'b1) begin
      n_mismatch++;
      summarize;
    end
  end
endmodule  // tb_detect_charge_status_latches
`default_nettype wire
